// ### rtl/slt_pkg.sv
// constants, types and codes shared by the serial link test block
package slt_pkg;

  // register port
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_TEST_PATTERN = 12'h205;
  localparam logic [ADDR_W-1:0] ADDR_IDENTIFIER = 12'h206;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_CHAR = 12'h207;

  // field widths and reset values
  localparam int unsigned CODE_W = 5;
  localparam int unsigned FRAME_END_CHAR_CODE_W = 2;
  localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
  localparam logic [REG_W-1:0] IDENT_RESET = 8'h00;
  localparam logic [FRAME_END_CHAR_CODE_W-1:0] FRAME_END_CHAR_CODE_RESET = 2'h0;
  localparam logic [REG_W-1:0] IDENT_EVEN_MASK = 8'hFE;
  localparam logic [REG_W-1:0] IDENT_LINK_B_STEP = 8'h01;

  // lane word
  localparam int unsigned LANE_W = 16;
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_W = LANE_W + 1;

  // test pattern codes
  localparam logic [CODE_W-1:0] TP_NORMAL = 5'h00;
  localparam logic [CODE_W-1:0] TP_PRBS7 = 5'h01;
  localparam logic [CODE_W-1:0] TP_PRBS15 = 5'h02;
  localparam logic [CODE_W-1:0] TP_PRBS23 = 5'h03;
  localparam logic [CODE_W-1:0] TP_RAMP = 5'h04;
  localparam logic [CODE_W-1:0] TP_TRANSPORT = 5'h05;
  localparam logic [CODE_W-1:0] TP_D21_5 = 5'h06;
  localparam logic [CODE_W-1:0] TP_K28_5 = 5'h07;
  localparam logic [CODE_W-1:0] TP_ILA = 5'h08;
  localparam logic [CODE_W-1:0] TP_RPAT = 5'h09;
  localparam logic [CODE_W-1:0] TP_HOLD_LOW = 5'h0A;
  localparam logic [CODE_W-1:0] TP_HOLD_HIGH = 5'h0B;
  localparam logic [CODE_W-1:0] TP_PRBS9 = 5'h0D;
  localparam logic [CODE_W-1:0] TP_PRBS31 = 5'h0E;
  localparam logic [CODE_W-1:0] TP_CLOCK = 5'h0F;
  localparam logic [CODE_W-1:0] TP_K28_7 = 5'h10;

  // frame end selector codes
  localparam logic [FRAME_END_CHAR_CODE_W-1:0] FC_K28_7 = 2'h0;
  localparam logic [FRAME_END_CHAR_CODE_W-1:0] FC_K28_1 = 2'h1;
  localparam logic [FRAME_END_CHAR_CODE_W-1:0] FC_K28_5 = 2'h2;

  // 8b/10b character octets
  localparam logic [7:0] CH_K28_0 = 8'h1C;
  localparam logic [7:0] CH_K28_1 = 8'h3C;
  localparam logic [7:0] CH_K28_3 = 8'h7C;
  localparam logic [7:0] CH_K28_4 = 8'h9C;
  localparam logic [7:0] CH_K28_5 = 8'hBC;
  localparam logic [7:0] CH_K28_7 = 8'hFC;
  localparam logic [7:0] CH_D21_5 = 8'hB5;

  // fixed words
  localparam logic [LANE_W-1:0] WORD_LOW = 16'h0000;
  localparam logic [LANE_W-1:0] WORD_HIGH = 16'hFFFF;
  localparam logic [LANE_W-1:0] WORD_CLOCK = 16'h00FF;
  localparam logic [CTRL_W-1:0] CTRL_NONE = 2'h0;
  localparam logic [CTRL_W-1:0] CTRL_BOTH = 2'h3;
  localparam logic [CTRL_W-1:0] CTRL_HIGH = 2'h2;
  localparam logic [CTRL_W-1:0] CTRL_LOW = 2'h1;

  // prbs generator: register width and feedback taps (1-based)
  localparam int unsigned LFSR_W = 31;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7FFFFFFF;
  localparam int unsigned TAP7_A = 7;
  localparam int unsigned TAP7_B = 6;
  localparam int unsigned TAP9_A = 9;
  localparam int unsigned TAP9_B = 5;
  localparam int unsigned TAP15_A = 15;
  localparam int unsigned TAP15_B = 14;
  localparam int unsigned TAP23_A = 23;
  localparam int unsigned TAP23_B = 18;
  localparam int unsigned TAP31_A = 31;
  localparam int unsigned TAP31_B = 28;

  // counters and alignment sequence
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] RAMP_STEP = 8'h02;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam int unsigned MF_W = 4;
  localparam logic [MF_W-1:0] MF_LAST = 4'hF;
  localparam logic [MF_W-1:0] MF_CONFIG = 4'h1;
  localparam int unsigned RPAT_LEN = 6;
  localparam int unsigned RPAT_IDX_W = 3;
  localparam logic [RPAT_IDX_W-1:0] RPAT_LAST = 3'h5;
  localparam logic [0:RPAT_LEN-1][LANE_W-1:0] RPAT_TABLE = {
    16'hBE17, 16'h4AB5, 16'hF3C9, 16'h650D, 16'h8E2A, 16'hD17C};

  // repeated alignment sequence: four multiframes, gray along the path
  typedef enum logic [1:0] {
    ILA_MF0 = 2'b00,
    ILA_MF1 = 2'b01,
    ILA_MF2 = 2'b11,
    ILA_MF3 = 2'b10
  } slt_ila_t;

  typedef struct packed {
    logic [LANE_W-1:0] data;
    logic [CTRL_W-1:0] ctrl;
  } slt_lane_t;

  typedef struct packed {
    logic frame_end;
    logic [LANE_W-1:0] data;
  } slt_sample_t;

endpackage

// ### rtl/slt_top.sv
// lane test pattern generator, alignment identifier and frame end logic
// What this block does
// - code zero sends normal converter data
// - codes 1-3 send PRBS7, PRBS15, PRBS23
// - codes 13, 14 send PRBS9, PRBS31
// - codes 4-6: ramp, transport, D21.5
// - codes 7,8,9,16: K28.5, ILA, RPAT, K28.7
// - code 10 holds low, 11 high
// - code 15 repeats clock word 0x00FF
// - K28.5, ILA, RPAT, K28.7 only in 8b/10b modes; D21.5 in all
// - identifier sent in second alignment multiframe
// - link A sends identifier, B plus one
// - identifier bit 0 forced and read zero
// - selector 0/1/2 picks K28.7/K28.1/K28.5
// - frame end substitution only in 8b/10b
`timescale 1ns/1ps

module slt_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic not_full;
    logic not_empty;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign push = in_valid_i && st.not_full;
  assign pop = out_ready_i && st.not_empty;
  assign in_ready_o = st.not_full;
  assign out_valid_o = st.not_empty;
  assign out_data_o = st.mem[st.rd_ptr];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data_i;
      next_st.wr_ptr = (st.wr_ptr == LAST_PTR) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == LAST_PTR) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    next_st.not_full = (next_st.count != FULL_CNT);
    next_st.not_empty = (next_st.count != '0);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.not_full <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

module slt_top
  import slt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [REG_W-1:0] reg_rdata_o,
  // link control from the rest of the transmitter
  input wire logic serial_link_enable_i,
  input wire logic link_mode_8b10b_i,
  // converter samples in
  input wire logic sample_valid_i,
  input wire logic [LANE_W-1:0] sample_data_i,
  input wire logic sample_frame_end_i,
  output logic sample_ready_o,
  // lane words towards the encoders
  input wire logic lane_ready_i,
  output logic lane_valid_o,
  output logic [LANE_W-1:0] lane_a_data_o,
  output logic [CTRL_W-1:0] lane_a_ctrl_o,
  output logic [LANE_W-1:0] lane_b_data_o,
  output logic [CTRL_W-1:0] lane_b_ctrl_o,
  output logic lane_raw_o,
  // alignment identifiers per link
  output logic [REG_W-1:0] link_a_identifier_o,
  output logic [REG_W-1:0] link_b_identifier_o
);

  typedef struct packed {
    logic [CODE_W-1:0] test_pattern_code;
    logic [REG_W-1:0] lane_alignment_identifier;
    logic [FRAME_END_CHAR_CODE_W-1:0] frame_end_char_code;
    logic [REG_W-1:0] rdata;
    logic [CODE_W-1:0] run_code;
    logic [LFSR_W-1:0] lfsr;
    logic [CNT_W-1:0] count;
    logic [RPAT_IDX_W-1:0] rpat_idx;
    slt_ila_t ila_mf;
    logic [MF_W-1:0] ila_word;
    logic [7:0] prev_last;
    logic valid;
    slt_lane_t lane_a;
    slt_lane_t lane_b;
    logic raw;
    logic [REG_W-1:0] ident_a;
    logic [REG_W-1:0] ident_b;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  slt_sample_t fifo_in;
  slt_sample_t fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_in_ready;

  // effective mode after masking K28.5, ILA, RPAT and K28.7 outside 8b/10b
  function automatic logic [CODE_W-1:0] eff_code(
    input logic [CODE_W-1:0] code,
    input logic is_8b10b
  );
    logic [CODE_W-1:0] res;
    res = code;
    unique case (code)
      TP_K28_5, TP_ILA, TP_RPAT, TP_K28_7: begin
        if (!is_8b10b) begin
          res = TP_NORMAL;
        end
      end
      TP_NORMAL, TP_PRBS7, TP_PRBS15, TP_PRBS23, TP_RAMP, TP_TRANSPORT,
      TP_D21_5, TP_HOLD_LOW, TP_HOLD_HIGH, TP_PRBS9, TP_PRBS31,
      TP_CLOCK: begin
        res = code;
      end
      default: begin
        res = TP_NORMAL;
      end
    endcase
    return res;
  endfunction

  function automatic logic is_prbs(input logic [CODE_W-1:0] code);
    return (code == TP_PRBS7) || (code == TP_PRBS9) ||
           (code == TP_PRBS15) || (code == TP_PRBS23) ||
           (code == TP_PRBS31);
  endfunction

  // sixteen shifts of the selected polynomial per lane word
  function automatic logic [LFSR_W-1:0] prbs_step(
    input logic [LFSR_W-1:0] s,
    input logic [CODE_W-1:0] code
  );
    logic [LFSR_W-1:0] r;
    logic fb;
    r = s;
    fb = 1'b0;
    for (int i = 0; i < LANE_W; i++) begin
      unique case (code)
        TP_PRBS7: fb = r[TAP7_A-1] ^ r[TAP7_B-1];
        TP_PRBS9: fb = r[TAP9_A-1] ^ r[TAP9_B-1];
        TP_PRBS15: fb = r[TAP15_A-1] ^ r[TAP15_B-1];
        TP_PRBS23: fb = r[TAP23_A-1] ^ r[TAP23_B-1];
        default: fb = r[TAP31_A-1] ^ r[TAP31_B-1];
      endcase
      r = {r[LFSR_W-2:0], fb};
    end
    return r;
  endfunction

  function automatic logic [7:0] frame_char(input logic [FRAME_END_CHAR_CODE_W-1:0] sel);
    logic [7:0] c;
    c = CH_K28_7;
    unique case (sel)
      FC_K28_1: c = CH_K28_1;
      FC_K28_5: c = CH_K28_5;
      default: c = CH_K28_7;
    endcase
    return c;
  endfunction

  assign fifo_in.frame_end = sample_frame_end_i;
  assign fifo_in.data = sample_data_i;
  // drain only while the encoder takes words; when disabled the source
  // stalls, in test modes samples are read and thrown away
  assign fifo_pop = serial_link_enable_i && lane_ready_i;

  slt_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(fifo_in),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .out_ready_i(fifo_pop)
  );

  always_comb begin
    logic [CODE_W-1:0] code;
    logic [LANE_W-1:0] word;
    logic [CTRL_W-1:0] ctrl;
    logic [LANE_W-1:0] word_b;
    logic [MF_W-1:0] ila_next;
    code = '0;
    word = WORD_LOW;
    ctrl = CTRL_NONE;
    word_b = WORD_LOW;
    ila_next = '0;
    next_st = st;

    // register writes; rule-level ordering on the enable is software's
    // job, writes while enabled are still accepted
    if (reg_write_i) begin
      unique case (reg_addr_i)
        ADDR_TEST_PATTERN: begin
          next_st.test_pattern_code = reg_wdata_i[CODE_W-1:0];
        end
        ADDR_IDENTIFIER: begin
          next_st.lane_alignment_identifier =
            reg_wdata_i & IDENT_EVEN_MASK;
        end
        ADDR_FRAME_CHAR: begin
          next_st.frame_end_char_code = reg_wdata_i[FRAME_END_CHAR_CODE_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // read data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        ADDR_TEST_PATTERN: begin
          next_st.rdata = REG_W'(st.test_pattern_code);
        end
        ADDR_IDENTIFIER: begin
          next_st.rdata = st.lane_alignment_identifier;
        end
        ADDR_FRAME_CHAR: begin
          next_st.rdata = REG_W'(st.frame_end_char_code);
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end

    next_st.ident_a = st.lane_alignment_identifier;
    next_st.ident_b =
      st.lane_alignment_identifier + IDENT_LINK_B_STEP;

    code = eff_code(st.test_pattern_code, link_mode_8b10b_i);
    next_st.valid = 1'b0;

    if (!serial_link_enable_i || code != st.run_code) begin
      // generators restart from a known point on any mode change
      next_st.run_code = code;
      next_st.lfsr = LFSR_SEED;
      next_st.count = '0;
      next_st.rpat_idx = '0;
      next_st.ila_mf = ILA_MF0;
      next_st.ila_word = '0;
      next_st.prev_last = '0;
      if (!serial_link_enable_i) begin
        next_st.lane_a = '0;
        next_st.lane_b = '0;
        next_st.raw = 1'b0;
      end
    end else if (lane_ready_i) begin
      unique case (code)
        TP_PRBS7, TP_PRBS9, TP_PRBS15, TP_PRBS23, TP_PRBS31: begin
          word = st.lfsr[LANE_W-1:0];
        end
        TP_RAMP: begin
          word = {st.count + CNT_ONE, st.count};
          next_st.count = st.count + RAMP_STEP;
        end
        TP_TRANSPORT: begin
          word = {st.count, ~st.count};
          next_st.count = st.count + CNT_ONE;
        end
        TP_D21_5: begin
          word = {CH_D21_5, CH_D21_5};
        end
        TP_K28_5: begin
          word = {CH_K28_5, CH_K28_5};
          ctrl = CTRL_BOTH;
        end
        TP_K28_7: begin
          word = {CH_K28_7, CH_K28_7};
          ctrl = CTRL_BOTH;
        end
        TP_RPAT: begin
          word = RPAT_TABLE[st.rpat_idx];
          next_st.rpat_idx =
            (st.rpat_idx == RPAT_LAST) ? '0 : st.rpat_idx + 1'b1;
        end
        TP_ILA: begin
          // each multiframe opens with K28.0 and closes with K28.3
          word = {st.count, st.count};
          if (st.ila_word == '0) begin
            word = {CH_K28_0, st.count};
            ctrl = CTRL_HIGH;
          end else if (st.ila_word == MF_LAST) begin
            word = {st.count, CH_K28_3};
            ctrl = CTRL_LOW;
          end else if (st.ila_mf == ILA_MF1 && st.ila_word == MF_CONFIG) begin
            word = {CH_K28_4, st.lane_alignment_identifier};
            ctrl = CTRL_HIGH;
          end
          next_st.count = st.count + CNT_ONE;
          ila_next = st.ila_word + 1'b1;
          next_st.ila_word = ila_next;
          if (st.ila_word == MF_LAST) begin
            unique case (st.ila_mf)
              ILA_MF0: next_st.ila_mf = ILA_MF1;
              ILA_MF1: next_st.ila_mf = ILA_MF2;
              ILA_MF2: next_st.ila_mf = ILA_MF3;
              ILA_MF3: next_st.ila_mf = ILA_MF0;
            endcase
          end
        end
        TP_HOLD_LOW: begin
          word = WORD_LOW;
        end
        TP_HOLD_HIGH: begin
          word = WORD_HIGH;
        end
        TP_CLOCK: begin
          word = WORD_CLOCK;
        end
        default: begin
          // normal data; a stalled fifo repeats zeros rather than
          // inventing samples
          word = fifo_out_valid ? fifo_out.data : WORD_LOW;
          if (fifo_out_valid && fifo_out.frame_end) begin
            next_st.prev_last = fifo_out.data[7:0];
            // substitute only when the last octet repeats the previous
            // frame's last octet, so the receiver can restore it
            if (link_mode_8b10b_i &&
                fifo_out.data[7:0] == st.prev_last) begin
              word = {fifo_out.data[LANE_W-1:8],
                      frame_char(st.frame_end_char_code)};
              ctrl = CTRL_LOW;
            end
          end
        end
      endcase
      if (is_prbs(code)) begin
        next_st.lfsr = prbs_step(st.lfsr, code);
      end
      word_b = word;
      if (code == TP_ILA && st.ila_mf == ILA_MF1 &&
          st.ila_word == MF_CONFIG) begin
        word_b = {CH_K28_4, next_st.ident_b};
      end
      next_st.valid = 1'b1;
      next_st.lane_a.data = word;
      next_st.lane_a.ctrl = link_mode_8b10b_i ? ctrl : CTRL_NONE;
      next_st.lane_b.data = word_b;
      next_st.lane_b.ctrl = link_mode_8b10b_i ? ctrl : CTRL_NONE;
      // held levels and the clock word bypass the line encoder
      next_st.raw = (code == TP_HOLD_LOW) || (code == TP_HOLD_HIGH) ||
                    (code == TP_CLOCK);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.test_pattern_code <= CODE_RESET;
      st.lane_alignment_identifier <= IDENT_RESET;
      st.frame_end_char_code <= FRAME_END_CHAR_CODE_RESET;
      st.ila_mf <= ILA_MF0;
      st.lfsr <= LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  // sample_ready comes from the fifo's registered full flag
  assign sample_ready_o = fifo_in_ready;
  assign reg_rdata_o = st.rdata;
  assign lane_valid_o = st.valid;
  assign lane_a_data_o = st.lane_a.data;
  assign lane_a_ctrl_o = st.lane_a.ctrl;
  assign lane_b_data_o = st.lane_b.data;
  assign lane_b_ctrl_o = st.lane_b.ctrl;
  assign lane_raw_o = st.raw;
  assign link_a_identifier_o = st.ident_a;
  assign link_b_identifier_o = st.ident_b;

endmodule

// ### testbench/slt_top_sva.sv
// port assertions for the lane test pattern block
`timescale 1ns/1ps
module slt_top_sva
  import slt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [REG_W-1:0] reg_rdata_o,
  // link control
  input wire logic serial_link_enable_i,
  input wire logic link_mode_8b10b_i,
  // lane and identifier outputs
  input wire logic lane_valid_o,
  input wire logic [LANE_W-1:0] lane_a_data_o,
  input wire logic [CTRL_W-1:0] lane_a_ctrl_o,
  input wire logic lane_raw_o,
  input wire logic [REG_W-1:0] link_a_identifier_o,
  input wire logic [REG_W-1:0] link_b_identifier_o
);
  logic [CODE_W-1:0] code_q;
  logic mode_q;
  logic [1:0] age;
  logic st;
  logic code_wr;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  assign code_wr = reg_write_i && reg_addr_i == ADDR_TEST_PATTERN;
  // a word is judged only once code and mode have been steady for a while,
  // since the first word after a change reflects the old setting
  assign st = lane_valid_o && age == 2'h3;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_q <= CODE_RESET;
      mode_q <= 1'b0;
      age <= 2'h0;
    end else begin
      mode_q <= link_mode_8b10b_i;
      if (code_wr) begin
        code_q <= reg_wdata_i[CODE_W-1:0];
      end
      if (code_wr || mode_q != link_mode_8b10b_i || !serial_link_enable_i) begin
        age <= 2'h0;
      end else if (age != 2'h3) begin
        age <= age + 2'h1;
      end
    end
  end

  AST_LOW: assert property (
    st && code_q == TP_HOLD_LOW |-> lane_a_data_o == WORD_LOW && lane_raw_o)
    else $error("hold low word wrong");
  AST_HIGH: assert property (
    st && code_q == TP_HOLD_HIGH |-> lane_a_data_o == WORD_HIGH && lane_raw_o)
    else $error("hold high word wrong");
  AST_CLOCK: assert property (
    st && code_q == TP_CLOCK |-> lane_a_data_o == WORD_CLOCK && lane_raw_o)
    else $error("clock word wrong");
  AST_D21: assert property (
    st && code_q == TP_D21_5 |-> lane_a_data_o == {CH_D21_5, CH_D21_5})
    else $error("D21.5 word wrong");
  AST_K285: assert property (
    st && code_q == TP_K28_5 && link_mode_8b10b_i
    |-> lane_a_data_o == {CH_K28_5, CH_K28_5} && lane_a_ctrl_o == CTRL_BOTH)
    else $error("K28.5 word wrong");
  AST_K_IN_64: assert property (
    st && code_q == TP_K28_7 && !link_mode_8b10b_i |-> lane_a_ctrl_o == CTRL_NONE)
    else $error("control character in 64b/66b mode");
  AST_RESERVED: assert property (
    st && code_q == 5'h0C |-> !lane_raw_o)
    else $error("reserved code changed the lane");
  AST_FRAME_64: assert property (
    st && code_q == TP_NORMAL && !link_mode_8b10b_i |-> lane_a_ctrl_o == CTRL_NONE)
    else $error("frame end substituted in 64b/66b mode");
  AST_ID_A: assert property (
    reg_write_i && reg_addr_i == ADDR_IDENTIFIER |-> ##2
    link_a_identifier_o == ($past(reg_wdata_i, 2) & IDENT_EVEN_MASK))
    else $error("link A identifier wrong");
  AST_ID_B: assert property (
    reg_write_i && reg_addr_i == ADDR_IDENTIFIER |-> ##2 link_b_identifier_o
    == (($past(reg_wdata_i, 2) & IDENT_EVEN_MASK) + IDENT_LINK_B_STEP))
    else $error("link B identifier wrong");
  AST_RD_EVEN: assert property (
    reg_read_i && reg_addr_i == ADDR_IDENTIFIER |=> !reg_rdata_o[0])
    else $error("identifier bit 0 read as one");
endmodule

bind slt_top slt_top_sva chk_i (.core_clk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
  .serial_link_enable_i, .link_mode_8b10b_i, .lane_valid_o, .lane_a_data_o,
  .lane_a_ctrl_o, .lane_raw_o, .link_a_identifier_o, .link_b_identifier_o);

// ### testbench/slt_far_rx.sv
// far end receiver model: paces lane_ready and records lane words
`timescale 1ns/1ps
module slt_far_rx
  import slt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // pacing
  input wire logic stall_i,
  // lane words
  input wire logic lane_valid_i,
  input wire slt_lane_t lane_a_i,
  input wire slt_lane_t lane_b_i,
  input wire logic lane_raw_i,
  output logic lane_ready_o
);
  slt_lane_t qa[$];
  slt_lane_t qb[$];
  logic qr[$];

  // a slow receiver takes a word only every other cycle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_ready_o <= 1'b0;
    end else begin
      lane_ready_o <= stall_i ? !lane_ready_o : 1'b1;
    end
  end

  // any end character is taken as sent; no comma realignment here
  always @(posedge core_clk_i) begin
    if (rstn_i && lane_valid_i) begin
      qa.push_back(lane_a_i);
      qb.push_back(lane_b_i);
      qr.push_back(lane_raw_i);
    end
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the lane test pattern block
`timescale 1ns/1ps
module testbench;
  import slt_pkg::*;
  localparam logic [4:0] FX_CODE [6] = '{5'h06, 5'h07, 5'h10, 5'h0A, 5'h0B,
    5'h0F};
  localparam logic [18:0] FX_EXP [6] = '{{16'hB5B5, CTRL_NONE, 1'b0},
    {16'hBCBC, CTRL_BOTH, 1'b0}, {16'hFCFC, CTRL_BOTH, 1'b0},
    {WORD_LOW, CTRL_NONE, 1'b1}, {WORD_HIGH, CTRL_NONE, 1'b1},
    {WORD_CLOCK, CTRL_NONE, 1'b1}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [REG_W-1:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic en = 1'b0;
  logic m8 = 1'b0;
  logic stall = 1'b0;
  logic s_valid = 1'b0;
  logic s_fe = 1'b0;
  logic [LANE_W-1:0] s_data = 16'h0000;
  logic [REG_W-1:0] rdata, id_a, id_b;
  logic s_ready, l_ready, l_valid, raw;
  slt_lane_t la, lb;
  int miscompares = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  slt_top DUT (.core_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .serial_link_enable_i(en), .link_mode_8b10b_i(m8),
    .sample_valid_i(s_valid), .sample_data_i(s_data),
    .sample_frame_end_i(s_fe), .sample_ready_o(s_ready),
    .lane_ready_i(l_ready), .lane_valid_o(l_valid),
    .lane_a_data_o(la.data), .lane_a_ctrl_o(la.ctrl),
    .lane_b_data_o(lb.data), .lane_b_ctrl_o(lb.ctrl), .lane_raw_o(raw),
    .link_a_identifier_o(id_a), .link_b_identifier_o(id_b));

  slt_far_rx far (.core_clk_i(clk), .rstn_i(rstn), .stall_i(stall),
    .lane_valid_i(l_valid), .lane_a_i(la), .lane_b_i(lb), .lane_raw_i(raw),
    .lane_ready_o(l_ready));

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(logic [39:0] seen, logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rdc(logic [ADDR_W-1:0] a, logic [REG_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(40'(rdata), 40'(e));
  endtask

  task automatic setup(logic [REG_W-1:0] c, logic m, logic [REG_W-1:0] f);
    @(posedge clk);
    en <= 1'b0;
    wr(ADDR_TEST_PATTERN, c);
    wr(ADDR_FRAME_CHAR, f);
    m8 <= m;
    far.qa.delete();
    far.qb.delete();
    far.qr.delete();
  endtask

  task automatic go(int n);
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 400 && far.qa.size() < n; i++) @(posedge clk);
    en <= 1'b0;
    chk(40'(far.qa.size() >= n), 40'h1);
    repeat (2) @(posedge clk);
  endtask

  task automatic push(logic [LANE_W-1:0] d, logic fe);
    int i;
    @(posedge clk);
    s_valid <= 1'b1;
    s_data <= d;
    s_fe <= fe;
    #1;
    for (i = 0; i < 100 && s_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(40'(s_ready), 40'h1);
    @(posedge clk);
    s_valid <= 1'b0;
  endtask

  function automatic logic [15:0] prbs(int ta, int tb, int k);
    logic [30:0] s;
    s = 31'h7FFFFFFF;
    repeat (16 * k) s = {s[29:0], s[ta-1] ^ s[tb-1]};
    return s[15:0];
  endfunction

  task automatic t_regs();
    rdc(ADDR_TEST_PATTERN, 8'h00);
    rdc(ADDR_IDENTIFIER, 8'h00);
    rdc(ADDR_FRAME_CHAR, 8'h00);
    wr(ADDR_IDENTIFIER, 8'h13);
    rdc(ADDR_IDENTIFIER, 8'h12);
    chk(40'({id_a, id_b}), 40'h1213);
    wr(ADDR_TEST_PATTERN, 8'hFF);
    wr(ADDR_FRAME_CHAR, 8'hFF);
    rdc(ADDR_TEST_PATTERN, 8'h1F);
    rdc(ADDR_FRAME_CHAR, 8'h03);
    rdc(12'h208, 8'h00);
  endtask

  task automatic t_fixed();
    for (int i = 0; i < 6; i++) begin
      setup(8'(FX_CODE[i]), 1'b1, 8'h00);
      go(3);
      chk(40'({far.qa[2], far.qr[2]}), 40'(FX_EXP[i]));
    end
    setup(8'h05, 1'b1, 8'h00);
    go(2);
    chk(40'({far.qa[1], far.qr[1]}), 40'({16'h01FE, 3'h0}));
    setup(8'h09, 1'b1, 8'h00);
    go(2);
    chk(40'({far.qa[1], far.qr[1]}), 40'({RPAT_TABLE[1], 3'h0}));
  endtask

  task automatic t_prbs();
    int c[5] = '{1, 2, 3, 13, 14};
    int ta[5] = '{TAP7_A, TAP15_A, TAP23_A, TAP9_A, TAP31_A};
    int tb[5] = '{TAP7_B, TAP15_B, TAP23_B, TAP9_B, TAP31_B};
    for (int i = 0; i < 5; i++) begin
      setup(8'(c[i]), 1'b1, 8'h00);
      go(3);
      for (int k = 0; k < 3; k++) begin
        chk(40'(far.qa[k].data), 40'(prbs(ta[i], tb[i], k)));
        chk(40'(far.qb[k].data), 40'(prbs(ta[i], tb[i], k)));
      end
    end
  endtask

  task automatic t_ramp_ila();
    stall <= 1'b1;
    setup(8'(TP_RAMP), 1'b1, 8'h00);
    go(4);
    for (int k = 0; k < 4; k++) begin
      chk(40'(far.qa[k].data), 40'({8'(2 * k + 1), 8'(2 * k)}));
    end
    stall <= 1'b0;
    setup(8'(TP_ILA), 1'b1, 8'h00);
    wr(ADDR_IDENTIFIER, 8'h21);
    go(18);
    chk(40'({far.qa[0].data[15:8], far.qa[0].ctrl}), 40'({CH_K28_0, 2'h2}));
    chk(40'(far.qa[17]), 40'({CH_K28_4, 8'h20, 2'h2}));
    chk(40'(far.qb[17]), 40'({CH_K28_4, 8'h21, 2'h2}));
  endtask

  task automatic t_normal();
    logic [7:0] ch[4] = '{CH_K28_7, CH_K28_1, CH_K28_5, CH_K28_7};
    logic [4:0] nc[4] = '{5'h10, 5'h0C, 5'h11, 5'h00};
    stall <= 1'b1;
    setup(8'h00, 1'b1, 8'h00);
    for (int i = 1; i <= 8; i++) push(16'(i * 16'h0101), 1'b0);
    #1 chk(40'(s_ready), 40'h0);
    go(8);
    for (int i = 0; i < 8; i++) begin
      chk(40'(far.qa[i]), 40'({16'((i + 1) * 16'h0101), CTRL_NONE}));
    end
    stall <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      setup(8'h00, 1'b1, 8'(f));
      push(16'h5A00, 1'b1);
      go(1);
      chk(40'(far.qa[0]), 40'({8'h5A, ch[f], CTRL_LOW}));
    end
    for (int i = 0; i < 4; i++) begin
      setup(8'(nc[i]), i == 1, 8'h02);
      push(16'h4300, i == 3);
      go(4);
      chk(40'({far.qa[0], far.qr[0]}), 40'({16'h4300, CTRL_NONE, 1'b0}));
    end
  endtask

  initial begin
    #(25 * 60000);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_fixed();
    t_prbs();
    t_ramp_ila();
    t_normal();
    summarize();
  end
endmodule
